// >>> multi_uart_line_select.sv
// Purpose: eight-uart line card with line-select decoding and flag selection
// Assumes: scanner inputs synchronous to CLK_SYS_I; two cards form sixteen lines
// Notes: unaddressed card holds status and data outputs at zero for or-ing
// Behaviour
// - transmit byte goes to all eight uarts; only the strobed one captures it
// - load strobes come from a one-of-eight decode of the 3-bit line code
// - received bytes share one wired-or bus, driven only when enable is low
// - the shared received byte bus is inverted before leaving the card
// - receive enable picked by one-of-eight decode of scanner's code
// - after acceptance the selected uart's avail reset is pulled low
// - avail flag rises when a whole character reaches the holding register
// - overrun flag rises when a new character lands before the old is read
// - framing flag rises when the stop bit is missing
// - parity flag rises when received parity disagrees with the setting
// - each of four flags selected from eight uarts by the scanner's code
// - selected flags of both cards are or-ed for one-of-sixteen selection
// - low six line parameter bits set uart format, delivered inverted
`timescale 1ns/1ps
`default_nettype none
module multi_uart_line_select #(
	parameter int unsigned BIT_CYCLES = mux_uart_pkg::CLK_HZ / mux_uart_pkg::BAUD_DEFAULT
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	// wishbone classic slave
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [3:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	output logic IRQ_O,
	// scanner side
	input wire logic CARD_ID_I,
	input wire logic [7:0] TX_DATA_I,
	input wire logic [3:0] TX_LINE_I,
	input wire logic TX_LOAD_I,
	input wire logic [3:0] RX_LINE_I,
	input wire logic RX_ACCEPT_I,
	output logic [7:0] RX_DATA_O,
	output logic RX_AVAIL_O,
	output logic RX_OVERRUN_O,
	output logic RX_FRAMING_O,
	output logic RX_PARITY_O,
	// serial lines
	input wire logic [7:0] SERIAL_RX_I,
	output logic [7:0] SERIAL_TX_O
);
	import mux_uart_pkg::*;

	logic [7:0] tx_strobe_q, tx_strobe_d, rde_n_q, rde_n_d, rda_n_q, rda_n_d;
	logic [7:0] tx_data_q;
	logic [5:0] lpr_q, lpr_d;
	logic [7:0] avail_v, ovr_v, fe_v, pe_v, done_v, serial_tx_v;
	logic [7:0] rx_bus_v [NUM_LINES];
	logic [7:0] bus_or;

	////////////////////////////////////////////////////////////////////
	// uart instances
	genvar gi;
	generate
		for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
			uart_line_if lif();
			assign lif.tx_data = tx_data_q;
			assign lif.tx_strobe = tx_strobe_q[gi];
			assign lif.rde_n = rde_n_q[gi];
			assign lif.rda_n = rda_n_q[gi];
			assign lif.cfg_n = ~lpr_q;
			assign rx_bus_v[gi] = lif.rx_bus;
			assign avail_v[gi] = lif.avail;
			assign ovr_v[gi] = lif.overrun;
			assign fe_v[gi] = lif.framing;
			assign pe_v[gi] = lif.parity;
			assign done_v[gi] = lif.done;
			uart_line #(.BIT_CYCLES(BIT_CYCLES)) u_line (
				.clk_i(CLK_SYS_I),
				.rst_i(RST_I),
				.lif(lif.line),
				.serial_rx_i(SERIAL_RX_I[gi]),
				.serial_tx_o(serial_tx_v[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// line-select decoders
	logic rx_addr_q, rx_addr_d;
	logic [2:0] rx_sel_q, rx_sel_d;

	always_comb begin
		tx_strobe_d = 8'h00;
		rde_n_d = 8'hFF;
		rda_n_d = 8'hFF;
		rx_addr_d = RX_LINE_I[3] == CARD_ID_I;
		rx_sel_d = RX_LINE_I[2:0];
		// trigger and code come from the transmitter scanner
		if (TX_LOAD_I && TX_LINE_I[3] == CARD_ID_I) begin
			tx_strobe_d[TX_LINE_I[2:0]] = 1'b1;
		end
		if (rx_addr_d) begin
			rde_n_d[rx_sel_d] = 1'b0;
			rda_n_d[rx_sel_d] = ~RX_ACCEPT_I;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			tx_strobe_q <= 8'h00;
			tx_data_q <= 8'h00;
			rde_n_q <= 8'hFF;
			rda_n_q <= 8'hFF;
			rx_addr_q <= 1'b0;
			rx_sel_q <= 3'h0;
		end else begin
			tx_strobe_q <= tx_strobe_d;
			tx_data_q <= TX_DATA_I;
			rde_n_q <= rde_n_d;
			rda_n_q <= rda_n_d;
			rx_addr_q <= rx_addr_d;
			rx_sel_q <= rx_sel_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// shared receive bus and flag selectors
	always_comb begin
		bus_or = 8'h00;
		for (int i = 0; i < NUM_LINES; i++) begin
			bus_or = bus_or | rx_bus_v[i];
		end
	end

	logic [7:0] rx_data_d;
	logic rx_av_d, rx_or_d, rx_fe_d, rx_pe_d;
	always_comb begin
		// zero when unaddressed so the two cards' outputs can simply be or-ed
		rx_data_d = rx_addr_q ? ~bus_or : 8'h00;
		rx_av_d = rx_addr_q & avail_v[rx_sel_q];
		rx_or_d = rx_addr_q & ovr_v[rx_sel_q];
		rx_fe_d = rx_addr_q & fe_v[rx_sel_q];
		rx_pe_d = rx_addr_q & pe_v[rx_sel_q];
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			RX_DATA_O <= 8'h00;
			RX_AVAIL_O <= 1'b0;
			RX_OVERRUN_O <= 1'b0;
			RX_FRAMING_O <= 1'b0;
			RX_PARITY_O <= 1'b0;
			SERIAL_TX_O <= 8'hFF;
		end else begin
			RX_DATA_O <= rx_data_d;
			RX_AVAIL_O <= rx_av_d;
			RX_OVERRUN_O <= rx_or_d;
			RX_FRAMING_O <= rx_fe_d;
			RX_PARITY_O <= rx_pe_d;
			SERIAL_TX_O <= serial_tx_v;
		end
	end

	////////////////////////////////////////////////////////////////////
	// wishbone registers and interrupts
	logic ack_d, irq_d;
	logic [31:0] dat_d;
	logic [3:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d, irq_ev;
	logic wr_take;

	assign irq_ev[IRQ_AVAIL] = |done_v;
	assign irq_ev[IRQ_OVERRUN] = |(done_v & ovr_v);
	assign irq_ev[IRQ_FRAMING] = |(done_v & fe_v);
	assign irq_ev[IRQ_PARITY] = |(done_v & pe_v);
	// the write lands on the edge where the master sees ack
	assign wr_take = CYC_I & STB_I & WE_I & ACK_O & SEL_I[0];

	always_comb begin
		ack_d = CYC_I & STB_I & ~ACK_O;
		lpr_d = lpr_q;
		irq_mask_d = irq_mask_q;
		irq_st_d = irq_st_q;
		dat_d = 32'h0000_0000;
		if (wr_take) begin
			unique case (ADR_I)
				OFS_LINE_PARAM: lpr_d = DAT_I[LPR_W-1:0];
				OFS_IRQ_STATUS: irq_st_d = irq_st_q & ~DAT_I[IRQ_W-1:0];
				OFS_IRQ_MASK: irq_mask_d = DAT_I[IRQ_W-1:0];
				default: ;
			endcase
		end
		// a new event wins over a clear in the same cycle
		irq_st_d = irq_st_d | irq_ev;
		if (ack_d) begin
			unique case (ADR_I)
				OFS_LINE_PARAM: dat_d = {26'h000_0000, lpr_q};
				OFS_LINE_AVAIL: dat_d = {24'h00_0000, avail_v};
				OFS_IRQ_STATUS: dat_d = {28'h000_0000, irq_st_q};
				OFS_IRQ_MASK: dat_d = {28'h000_0000, irq_mask_q};
				default: dat_d = 32'h0000_0000;
			endcase
		end
		irq_d = |(irq_st_q & irq_mask_q);
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h0000_0000;
			IRQ_O <= 1'b0;
			lpr_q <= LPR_RESET;
			irq_st_q <= 4'h0;
			irq_mask_q <= IRQ_MASK_RESET;
		end else begin
			ACK_O <= ack_d;
			DAT_O <= dat_d;
			IRQ_O <= irq_d;
			lpr_q <= lpr_d;
			irq_st_q <= irq_st_d;
			irq_mask_q <= irq_mask_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	AST_TX_ONE_STROBE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		$onehot0(tx_strobe_q)) else $error("more than one load strobe");
	AST_TX_STROBE_HIT: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(TX_LOAD_I && TX_LINE_I[3] == CARD_ID_I) |=> tx_strobe_q[$past(TX_LINE_I[2:0])])
		else $error("selected line not strobed");
	AST_RDE_ONE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		$onehot0(~rde_n_q) && (rx_addr_q || rde_n_q == 8'hFF)) else $error("bad receive enable");
	AST_RDA_PULSE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(RX_ACCEPT_I && RX_LINE_I[3] == CARD_ID_I) |=> !rda_n_q[$past(RX_LINE_I[2:0])] ##1 1)
		else $error("avail reset not driven");
	AST_RX_INVERT: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		rx_addr_q |=> RX_DATA_O == ~$past(bus_or)) else $error("receive bus not inverted");
	AST_IDLE_CARD: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		!rx_addr_q |=> RX_DATA_O == 8'h00 && !RX_AVAIL_O && !RX_OVERRUN_O && !RX_FRAMING_O && !RX_PARITY_O)
		else $error("unaddressed card drives outputs");
	AST_FLAG_SELECT: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		rx_addr_q |=> RX_AVAIL_O == $past(avail_v[rx_sel_q]) && RX_FRAMING_O == $past(fe_v[rx_sel_q]))
		else $error("wrong flag selected");
	AST_LPR_CFG: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(wr_take && ADR_I == OFS_LINE_PARAM) |=> g_line[0].lif.cfg_n == ~$past(DAT_I[5:0]))
		else $error("format not delivered inverted");
	AST_ACK_ONE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		ACK_O |=> !ACK_O) else $error("ack held two cycles");
	AST_IRQ: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		|(irq_st_q & irq_mask_q) |=> IRQ_O) else $error("interrupt not raised");
	AST_IRQ_LOW: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		!(|(irq_st_q & irq_mask_q)) |=> !IRQ_O) else $error("interrupt without masked status");
	AST_ACK_RESP: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(CYC_I && STB_I && !ACK_O) |=> ACK_O) else $error("request not acknowledged");
	AST_ACK_NO_REQ: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		!(CYC_I && STB_I) |=> !ACK_O) else $error("ack without request");
	AST_DAT_IDLE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		!ACK_O |-> DAT_O == 32'h0000_0000) else $error("read data outside ack");
	AST_STATUS_SET: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		|irq_ev |=> (irq_st_q & $past(irq_ev)) == $past(irq_ev)) else $error("event lost to clear");
	AST_MASK_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(wr_take && ADR_I == OFS_IRQ_MASK) |=> irq_mask_q == $past(DAT_I[3:0])) else $error("mask not written");
	AST_LPR_KEEP: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		!(wr_take && ADR_I == OFS_LINE_PARAM) |=> lpr_q == $past(lpr_q)) else $error("format changed");
	AST_TX_NO_STROBE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		!(TX_LOAD_I && TX_LINE_I[3] == CARD_ID_I) |=> tx_strobe_q == 8'h00) else $error("stray strobe");
	AST_RDA_IDLE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		!RX_ACCEPT_I |=> rda_n_q == 8'hFF) else $error("stray avail reset");
	AST_RDE_SEL: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		rx_addr_q |-> !rde_n_q[rx_sel_q]) else $error("selected line not enabled");
	AST_OVR_SELECT: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		rx_addr_q |=> RX_OVERRUN_O == $past(ovr_v[rx_sel_q]) && RX_PARITY_O == $past(pe_v[rx_sel_q]))
		else $error("wrong error flag selected");
endmodule
`default_nettype wire

// >>> mux_uart_pkg.sv
// Purpose: shared constants for the eight-line uart card
// Assumes: 200 MHz system clock, classic wishbone register access
// Notes: offsets are byte addresses of 32-bit words
package mux_uart_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned BAUD_DEFAULT = 9600;
	localparam int unsigned NUM_LINES = 8;
	localparam int unsigned CNT_W = 16;

	// register map
	localparam logic [3:0] OFS_LINE_PARAM = 4'h0;
	localparam logic [3:0] OFS_LINE_AVAIL = 4'h4;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK = 4'hC;

	// line parameter fields and reset value (8 data bits, 1 stop, no parity)
	localparam int unsigned LPR_W = 6;
	localparam int unsigned LPR_LEN_LSB = 0;
	localparam int unsigned LPR_STOP_BIT = 2;
	localparam int unsigned LPR_PEN_BIT = 3;
	localparam int unsigned LPR_EVEN_BIT = 4;
	localparam logic [5:0] LPR_RESET = 6'h03;
	localparam logic [3:0] MIN_CHAR_LEN = 4'h5;

	// interrupt status / mask layout
	localparam int unsigned IRQ_W = 4;
	localparam int unsigned IRQ_AVAIL = 0;
	localparam int unsigned IRQ_OVERRUN = 1;
	localparam int unsigned IRQ_FRAMING = 2;
	localparam int unsigned IRQ_PARITY = 3;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	typedef enum logic [4:0] {
		SER_IDLE = 5'h01,
		SER_START = 5'h02,
		SER_DATA = 5'h04,
		SER_PARITY = 5'h08,
		SER_STOP = 5'h10
	} ser_state_t;
endpackage

// >>> serial_peer.sv
// Purpose: serial terminals feeding the card's receive inputs
// Assumes: bit time given in system clocks
// Notes: lines idle high between frames; one frame at a time
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
	parameter int unsigned BIT_CYCLES = 16
) (
	input wire logic clk_i,
	output logic [7:0] line_o
);
	initial line_o = 8'hFF;

	// 8 data bits lsb first; stop_bit low makes a broken frame
	task send_char(input int ln, input logic [7:0] data, input logic par_en, input logic par_bit,
		input logic stop_bit);
		logic [10:0] frame;
		int n;
		frame = par_en ? {stop_bit, par_bit, data, 1'b0} : {1'b1, stop_bit, data, 1'b0};
		n = par_en ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			line_o[ln] <= frame[i];
			repeat (BIT_CYCLES - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		line_o[ln] <= 1'b1;
		repeat (BIT_CYCLES) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// >>> tb_multi_uart_line_select.sv
// Purpose: self-checking bench for the eight-uart line card
// Assumes: BIT_CYCLES cut to 16 to keep frames short
// Notes: serial outputs are sampled on the falling edge; wishbone at the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_multi_uart_line_select;
	import mux_uart_pkg::*;
	localparam int unsigned BITC = 16;
	logic clk, rst, cyc, stb, we, card_id, tx_load, rx_accept, ack, irq;
	logic rx_av, rx_ov, rx_fe, rx_pe;
	logic [3:0] adr, sel, tx_line, rx_line;
	logic [31:0] dat_i, dat_o, q;
	logic [7:0] tx_data, rx_data, ser_rx, ser_tx;
	int mismatches, checks_done;

	serial_peer #(.BIT_CYCLES(BITC)) peer (.clk_i(clk), .line_o(ser_rx));

	multi_uart_line_select #(.BIT_CYCLES(BITC)) uut (
		.CLK_SYS_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
		.SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .IRQ_O(irq),
		.CARD_ID_I(card_id), .TX_DATA_I(tx_data), .TX_LINE_I(tx_line), .TX_LOAD_I(tx_load),
		.RX_LINE_I(rx_line), .RX_ACCEPT_I(rx_accept), .RX_DATA_O(rx_data), .RX_AVAIL_O(rx_av),
		.RX_OVERRUN_O(rx_ov), .RX_FRAMING_O(rx_fe), .RX_PARITY_O(rx_pe),
		.SERIAL_RX_I(ser_rx), .SERIAL_TX_O(ser_tx)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// classic cycle: hold until ack, take data, then release
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat_i <= d;
		// ack and read data are taken at the same rising edge
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		chk({31'h0, ack}, 32'h1, "ack");
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
		wb(1'b0, a, 32'h0000_0000);
		chk(q, exp, what);
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk_rx(input logic [7:0] d, input logic [3:0] f, input string what);
		chk({24'h0, rx_data}, {24'h0, d}, what);
		chk({28'h0, rx_av, rx_ov, rx_fe, rx_pe}, {28'h0, f}, what);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk_rx(8'h00, 4'h0, "reset rx");
		chk({24'h0, ser_tx}, 32'h0000_00FF, "reset tx idle");
		rd(OFS_LINE_PARAM, 32'h0000_0003, "lpr reset");
		rd(OFS_IRQ_MASK, 32'h0000_0000, "mask reset");
		rd(OFS_IRQ_STATUS, 32'h0000_0000, "status reset");
		wb(1'b1, 4'h1, 32'h0000_0000);
		rd(4'h1, 32'h0000_0000, "unmapped read");
		rd(OFS_LINE_PARAM, 32'h0000_0003, "lpr after unmapped write");
	endtask

	task automatic t_transmit(input int ln, input logic [7:0] b);
		logic [7:0] got;
		int n;
		n = 0;
		@(posedge clk);
		tx_line <= 4'(ln);
		tx_data <= b;
		tx_load <= 1'b1;
		@(posedge clk);
		tx_load <= 1'b0;
		while (ser_tx[ln] !== 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk({24'h0, ser_tx | (8'h01 << ln)}, 32'h0000_00FF, "only strobed line sends");
		idle(BITC / 2);
		chk({31'h0, ser_tx[ln]}, 32'h0, "start bit");
		for (int i = 0; i < 8; i++) begin
			idle(BITC);
			got[i] = ser_tx[ln];
		end
		idle(BITC);
		chk({24'h0, got}, {24'h0, b}, "tx byte");
		chk({31'h0, ser_tx[ln]}, 32'h1, "stop bit");
		idle(2 * BITC);
	endtask

	task automatic t_other_card_load;
		@(posedge clk);
		tx_line <= 4'hB;
		tx_load <= 1'b1;
		@(posedge clk);
		tx_load <= 1'b0;
		idle(40);
		chk({24'h0, ser_tx}, 32'h0000_00FF, "load for other card ignored");
	endtask

	task automatic t_receive;
		peer.send_char(5, 8'h5A, 1'b0, 1'b0, 1'b1);
		rx_line <= 4'h5;
		idle(4);
		chk_rx(8'h5A, 4'h8, "rx line 5");
		rd(OFS_LINE_AVAIL, 32'h0000_0020, "avail reg");
		rd(OFS_IRQ_STATUS, 32'h0000_0001, "char event");
		chk({31'h0, irq}, 32'h0, "masked irq");
		@(posedge clk);
		rx_line <= 4'h4;
		idle(3);
		chk_rx(8'h00, 4'h0, "idle line 4");
		@(posedge clk);
		rx_line <= 4'hD;
		idle(3);
		chk_rx(8'h00, 4'h0, "other card selected");
		wb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
		idle(3);
		chk({31'h0, irq}, 32'h1, "irq raised");
		wb(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
		idle(3);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		rd(OFS_IRQ_STATUS, 32'h0000_0000, "status cleared");
		@(posedge clk);
		rx_line <= 4'h5;
		rx_accept <= 1'b1;
		@(posedge clk);
		rx_accept <= 1'b0;
		idle(4);
		chk({31'h0, rx_av}, 32'h0, "avail cleared");
		rd(OFS_LINE_AVAIL, 32'h0000_0000, "avail reg cleared");
	endtask

	task automatic t_errors;
		@(posedge clk);
		rx_line <= 4'h2;
		peer.send_char(2, 8'h11, 1'b0, 1'b0, 1'b1);
		peer.send_char(2, 8'h22, 1'b0, 1'b0, 1'b1);
		idle(4);
		chk_rx(8'h22, 4'hC, "overrun");
		@(posedge clk);
		rx_line <= 4'h1;
		peer.send_char(1, 8'h33, 1'b0, 1'b0, 1'b0);
		idle(4);
		chk({31'h0, rx_fe}, 32'h1, "framing");
		wb(1'b1, OFS_LINE_PARAM, 32'h0000_001B);
		rd(OFS_LINE_PARAM, 32'h0000_001B, "lpr even parity");
		@(posedge clk);
		rx_line <= 4'h6;
		peer.send_char(6, 8'h07, 1'b1, 1'b0, 1'b1);
		idle(4);
		chk_rx(8'h07, 4'h9, "bad parity");
		peer.send_char(6, 8'h06, 1'b1, 1'b0, 1'b1);
		idle(4);
		chk({31'h0, rx_pe}, 32'h0, "good parity");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		complete_run();
	end

	initial begin
		rst = 1'b1;
		{cyc, stb, we, card_id, tx_load, rx_accept} = 6'h00;
		{adr, sel, tx_line, rx_line} = 16'h0000;
		dat_i = 32'h0000_0000;
		tx_data = 8'h00;
		mismatches = 0;
		checks_done = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		t_reset();
		t_transmit(3, 8'hA5);
		t_transmit(7, 8'h3C);
		t_other_card_load();
		t_receive();
		t_errors();
		complete_run();
	end
endmodule
`default_nettype wire

// >>> uart_line.sv
// Purpose: one uart with transmit and receive holding registers
// Assumes: serial input already synchronous to the clock
// Notes: configuration arrives inverted and is restored here
`timescale 1ns/1ps
`default_nettype none
module uart_line #(
	parameter int unsigned BIT_CYCLES = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	uart_line_if.line lif,
	input wire logic serial_rx_i,
	output logic serial_tx_o
);
	import mux_uart_pkg::*;
	localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
	localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2);

	logic [5:0] cfg;
	logic [3:0] char_len;
	assign cfg = ~lif.cfg_n;
	assign char_len = MIN_CHAR_LEN + {2'b00, cfg[LPR_LEN_LSB +: 2]};

	////////////////////////////////////////////////////////////////////
	// transmitter
	ser_state_t tx_st_q, tx_st_d;
	logic [7:0] tx_hold_q, tx_hold_d, tx_sh_q, tx_sh_d;
	logic tx_full_q, tx_full_d, tx_out_q, tx_out_d, tx_par_q, tx_par_d, tx_stop2_q, tx_stop2_d;
	logic [15:0] tx_cnt_q, tx_cnt_d;
	logic [3:0] tx_bit_q, tx_bit_d;

	always_comb begin
		tx_st_d = tx_st_q;
		tx_hold_d = tx_hold_q;
		tx_sh_d = tx_sh_q;
		tx_full_d = tx_full_q;
		tx_par_d = tx_par_q;
		tx_stop2_d = tx_stop2_q;
		tx_bit_d = tx_bit_q;
		tx_cnt_d = (tx_cnt_q == 16'h0000) ? BIT_LAST : tx_cnt_q - 16'h0001;
		tx_out_d = 1'b1;
		unique case (tx_st_q)
			SER_IDLE: begin
				tx_cnt_d = BIT_LAST;
				if (tx_full_q) begin
					tx_sh_d = tx_hold_q;
					tx_full_d = 1'b0;
					tx_par_d = 1'b0;
					tx_st_d = SER_START;
					tx_out_d = 1'b0;
				end
			end
			SER_START: begin
				tx_out_d = 1'b0;
				if (tx_cnt_q == 16'h0000) begin
					tx_st_d = SER_DATA;
					tx_bit_d = 4'h0;
					tx_out_d = tx_sh_q[0];
				end
			end
			SER_DATA: begin
				tx_out_d = tx_sh_q[0];
				if (tx_cnt_q == 16'h0000) begin
					tx_par_d = tx_par_q ^ tx_sh_q[0];
					tx_sh_d = {1'b0, tx_sh_q[7:1]};
					tx_bit_d = tx_bit_q + 4'h1;
					tx_stop2_d = cfg[LPR_STOP_BIT];
					if (tx_bit_q == char_len - 4'h1) begin
						tx_st_d = cfg[LPR_PEN_BIT] ? SER_PARITY : SER_STOP;
						tx_out_d = cfg[LPR_PEN_BIT] ? ~(tx_par_d ^ cfg[LPR_EVEN_BIT]) : 1'b1;
					end else begin
						tx_out_d = tx_sh_q[1];
					end
				end
			end
			SER_PARITY: begin
				// even: bit makes the total even; odd: complement
				tx_out_d = ~(tx_par_q ^ cfg[LPR_EVEN_BIT]);
				if (tx_cnt_q == 16'h0000) begin
					tx_st_d = SER_STOP;
					tx_out_d = 1'b1;
				end
			end
			SER_STOP: begin
				if (tx_cnt_q == 16'h0000) begin
					tx_stop2_d = 1'b0;
					tx_st_d = tx_stop2_q ? SER_STOP : SER_IDLE;
				end
			end
		endcase
		// capture after the move so a strobe in the move cycle is kept
		if (lif.tx_strobe) begin
			tx_hold_d = lif.tx_data;
			tx_full_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_st_q <= SER_IDLE;
			tx_hold_q <= 8'h00;
			tx_sh_q <= 8'h00;
			tx_full_q <= 1'b0;
			tx_out_q <= 1'b1;
			tx_par_q <= 1'b0;
			tx_stop2_q <= 1'b0;
			tx_cnt_q <= 16'h0000;
			tx_bit_q <= 4'h0;
		end else begin
			tx_st_q <= tx_st_d;
			tx_hold_q <= tx_hold_d;
			tx_sh_q <= tx_sh_d;
			tx_full_q <= tx_full_d;
			tx_out_q <= tx_out_d;
			tx_par_q <= tx_par_d;
			tx_stop2_q <= tx_stop2_d;
			tx_cnt_q <= tx_cnt_d;
			tx_bit_q <= tx_bit_d;
		end
	end
	assign serial_tx_o = tx_out_q;

	////////////////////////////////////////////////////////////////////
	// receiver
	ser_state_t rx_st_q, rx_st_d;
	logic [7:0] rx_sh_q, rx_sh_d, rx_hold_q, rx_hold_d;
	logic [15:0] rx_cnt_q, rx_cnt_d;
	logic [3:0] rx_bit_q, rx_bit_d;
	logic rx_par_q, rx_par_d, rx_perr_q, rx_perr_d;
	logic da_q, da_d, or_q, or_d, fe_q, fe_d, pe_q, pe_d, done_q, done_d;

	always_comb begin
		rx_st_d = rx_st_q;
		rx_sh_d = rx_sh_q;
		rx_hold_d = rx_hold_q;
		rx_bit_d = rx_bit_q;
		rx_par_d = rx_par_q;
		rx_perr_d = rx_perr_q;
		or_d = or_q;
		fe_d = fe_q;
		pe_d = pe_q;
		done_d = 1'b0;
		rx_cnt_d = (rx_cnt_q == 16'h0000) ? BIT_LAST : rx_cnt_q - 16'h0001;
		da_d = da_q & lif.rda_n;
		unique case (rx_st_q)
			SER_IDLE: begin
				rx_cnt_d = HALF_LAST;
				if (!serial_rx_i) begin
					rx_st_d = SER_START;
				end
			end
			SER_START: begin
				if (rx_cnt_q == 16'h0000) begin
					rx_st_d = serial_rx_i ? SER_IDLE : SER_DATA;
					rx_bit_d = 4'h0;
					rx_par_d = 1'b0;
					rx_sh_d = 8'h00;
				end
			end
			SER_DATA: begin
				if (rx_cnt_q == 16'h0000) begin
					rx_sh_d[rx_bit_q[2:0]] = serial_rx_i;
					rx_par_d = rx_par_q ^ serial_rx_i;
					rx_bit_d = rx_bit_q + 4'h1;
					rx_perr_d = 1'b0;
					if (rx_bit_q == char_len - 4'h1) begin
						rx_st_d = cfg[LPR_PEN_BIT] ? SER_PARITY : SER_STOP;
					end
				end
			end
			SER_PARITY: begin
				if (rx_cnt_q == 16'h0000) begin
					rx_perr_d = (rx_par_q ^ serial_rx_i) == cfg[LPR_EVEN_BIT];
					rx_st_d = SER_STOP;
				end
			end
			SER_STOP: begin
				if (rx_cnt_q == 16'h0000) begin
					rx_st_d = SER_IDLE;
					rx_hold_d = rx_sh_q;
					done_d = 1'b1;
					or_d = da_q & lif.rda_n;
					fe_d = ~serial_rx_i;
					pe_d = rx_perr_q;
					da_d = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_st_q <= SER_IDLE;
			rx_sh_q <= 8'h00;
			rx_hold_q <= 8'h00;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 4'h0;
			rx_par_q <= 1'b0;
			rx_perr_q <= 1'b0;
			da_q <= 1'b0;
			or_q <= 1'b0;
			fe_q <= 1'b0;
			pe_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			rx_st_q <= rx_st_d;
			rx_sh_q <= rx_sh_d;
			rx_hold_q <= rx_hold_d;
			rx_cnt_q <= rx_cnt_d;
			rx_bit_q <= rx_bit_d;
			rx_par_q <= rx_par_d;
			rx_perr_q <= rx_perr_d;
			da_q <= da_d;
			or_q <= or_d;
			fe_q <= fe_d;
			pe_q <= pe_d;
			done_q <= done_d;
		end
	end

	// drivers are active low onto the wired bus, so contribute the complement
	assign lif.rx_bus = lif.rde_n ? 8'h00 : ~rx_hold_q;
	assign lif.avail = da_q;
	assign lif.overrun = or_q;
	assign lif.framing = fe_q;
	assign lif.parity = pe_q;
	assign lif.done = done_q;

	AST_DA_ON_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
		done_q |-> da_q && rx_st_q == SER_IDLE) else $error("char done without avail flag");
	AST_OVERRUN: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx_st_q == SER_STOP && rx_cnt_q == 16'h0000 && da_q && lif.rda_n) |=> or_q && done_q)
		else $error("overrun not flagged");
endmodule
`default_nettype wire

// >>> uart_line_if.sv
// Purpose: control and flag wires between the card logic and one uart
// Assumes: single clock domain
// Notes: enable and reset lines are active low as on the card
`timescale 1ns/1ps
`default_nettype none
interface uart_line_if;
	logic [7:0] tx_data;
	logic tx_strobe;
	logic rde_n;
	logic rda_n;
	logic [5:0] cfg_n;
	logic [7:0] rx_bus;
	logic avail;
	logic overrun;
	logic framing;
	logic parity;
	logic done;
	modport card (output tx_data, tx_strobe, rde_n, rda_n, cfg_n,
		input rx_bus, avail, overrun, framing, parity, done);
	modport line (input tx_data, tx_strobe, rde_n, rda_n, cfg_n,
		output rx_bus, avail, overrun, framing, parity, done);
endinterface
`default_nettype wire
